// ==== hdl/adcp_params.svh ====
// register map, field positions, reset values and delay figures of the
// converter accumulate and power control block; definitions only
`ifndef ADCP_PARAMS_SVH
`define ADCP_PARAMS_SVH

// --------------------------------------------------------------------
// special-function register addresses
// --------------------------------------------------------------------
`define ADCP_ADDR_ACC_CFG 8'hba
`define ADCP_ADDR_PWR_CTL 8'hbb
`define ADCP_ADDR_RES_LO 8'hd2
`define ADCP_ADDR_RES_HI 8'hd3

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define ADCP_ACC_CFG_RST 8'h00
`define ADCP_PWR_CTL_RST 8'h0f
`define ADCP_RES_RST 16'h0000

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define ADCP_ACC_EN_BIT 6
`define ADCP_SJ_MSB 5
`define ADCP_SJ_LSB 3
`define ADCP_RPT_MSB 2
`define ADCP_RPT_LSB 0
`define ADCP_LP_BIT 7
`define ADCP_PWR_MSB 3
`define ADCP_PWR_LSB 0

// --------------------------------------------------------------------
// delay figures and formats
// --------------------------------------------------------------------
`define ADCP_PWR_MULT 8'h08
`define ADCP_TRACK_EXTRA 2'h3
`define ADCP_BTRACK_BASE 8'h40
`define ADCP_LEFT_SHIFT 6
`define ADCP_SJ_LEFT 3'h4

`endif

// ==== hdl/adcp_pkg.sv ====
// types shared by the converter accumulate and power control block
// assumes the params header is compiled alongside
`default_nettype none
package adcp_pkg;
  typedef enum logic [1:0] {
    ADCP_IDLE = 2'b00,
    ADCP_PWRUP = 2'b01,
    ADCP_CONV = 2'b10,
    ADCP_BTRACK = 2'b11
  } adcp_state_t;
endpackage
`default_nettype wire

// ==== hdl/adcp_delay_timer.sv ====
// delay timer: counts oscillator ticks, then converter clock ticks
// assumes both tick inputs are one-cycle enables on sys_clk
`default_nettype none
module adcp_delay_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic load,
  input wire logic [7:0] osc_count,
  input wire logic [1:0] sar_count,
  input wire logic osc_tick,
  input wire logic sar_tick,
  // result
  output logic done_q
);
  logic [7:0] osc_cnt_q;
  logic [1:0] sar_cnt_q;
  logic busy_q;

  // --------------------------------------------------------------------
  // countdown: oscillator part first, extra converter clocks after
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_cnt_q <= 8'h00;
      sar_cnt_q <= 2'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load) begin
        osc_cnt_q <= osc_count;
        sar_cnt_q <= sar_count;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (osc_cnt_q != 8'h00) begin
          if (osc_tick) begin
            osc_cnt_q <= osc_cnt_q - 8'h01;
          end
        end else if (sar_cnt_q != 2'h0) begin
          if (sar_tick) begin
            sar_cnt_q <= sar_cnt_q - 2'h1;
          end
        end else begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/adcp_top.sv ====
// converter accumulate and power control: two config registers, result
// accumulator with formatted read, burst power-up and track sequencing
// assumes sfr strobes, ticks and converter signals are on sys_clk
//
// Behaviour
// R1 - the accumulate-enable bit is write-only and reads back as zero.
// R2 - outside burst with accumulate off, the result holds the latest conversion only.
// R3 - outside burst with accumulate on, each new result is added into the result.
// R4 - shift/justify codes 0-3 right justify with shift 0-3, code 4 left justifies unshifted.
// R5 - software must not use shift/justify codes 5 to 7.
// R6 - in burst, repeat codes 0-5 run and sum 1, 4, 8, 16, 32 or 64 conversions.
// R7 - software keeps the repeat count at zero while burst is off.
// R8 - software writes reset values into the reserved bits of both registers.
// R9 - the low-power bit cuts buffer power and software then allows longer tracking.
// R10 - a burst starts after eight times the power-up field in oscillator cycles.
// R11 - delayed tracking adds three converter clocks to the burst power-up delay.
// R12 - the done flag is set per conversion outside burst, per burst in burst, cleared by software.
// R13 - with delayed tracking, conversion starts three converter clocks after start, tracking meanwhile.
// R14 - no inter-conversion track delay comes before the first conversion of a burst.
// R15 - formatting is only on the read path; the accumulator keeps the raw sum.
`include "adcp_params.svh"
`default_nettype none
module adcp_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_q,
  // settings held elsewhere
  input wire logic burst_enable,
  input wire logic delayed_track_select,
  input wire logic [5:0] burst_track_delay,
  // rate enables
  input wire logic high_freq_oscillator_tick,
  input wire logic converter_clock_tick,
  // converter handshake
  input wire logic start_of_conversion,
  input wire logic conv_result_valid,
  input wire logic [9:0] conv_result,
  output logic conv_start_q,
  output logic tracking_q,
  output logic low_power_buffer_enable_q,
  // completion flag
  input wire logic conversion_done_clear,
  output logic conversion_done_flag_q
);
  import adcp_pkg::*;

  logic [7:0] acc_cfg_q;
  logic [7:0] pwr_ctl_q;
  logic accumulate_enable_q;
  logic [15:0] accum_q;
  adcp_state_t state_q;
  logic burst_q;
  logic first_q;
  logic [6:0] remaining_q;
  logic timer_load;
  logic [7:0] timer_osc;
  logic [1:0] timer_sar;
  logic timer_done;
  logic done_set;
  logic take_result;
  logic [15:0] conv_ext;
  logic [15:0] fmt_word;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [6:0] rpt_count(input logic [2:0] code);
    case (code)
      3'h1: rpt_count = 7'h04;
      3'h2: rpt_count = 7'h08;
      3'h3: rpt_count = 7'h10;
      3'h4: rpt_count = 7'h20;
      3'h5: rpt_count = 7'h40;
      default: rpt_count = 7'h01;
    endcase
  endfunction

  // left justify moves a 10-bit value to the top of the word
  function automatic logic [15:0] fmt_result(input logic [15:0] acc, input logic [2:0] sj);
    if (sj == `ADCP_SJ_LEFT) begin
      fmt_result = acc << `ADCP_LEFT_SHIFT; // R4
    end else begin
      fmt_result = acc >> sj[1:0]; // R4
    end
  endfunction

  // --------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------
  // reserved bits are stored as written; software keeps them at reset value
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_cfg_q <= `ADCP_ACC_CFG_RST;
      pwr_ctl_q <= `ADCP_PWR_CTL_RST;
    end else if (sfr_wr) begin
      if (sfr_addr == `ADCP_ADDR_ACC_CFG) begin
        acc_cfg_q <= sfr_wdata;
      end
      if (sfr_addr == `ADCP_ADDR_PWR_CTL) begin
        pwr_ctl_q <= sfr_wdata;
      end
    end
  end

  assign accumulate_enable_q = acc_cfg_q[`ADCP_ACC_EN_BIT];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_power_buffer_enable_q <= 1'b0;
    end else begin
      low_power_buffer_enable_q <= pwr_ctl_q[`ADCP_LP_BIT]; // R9
    end
  end

  // --------------------------------------------------------------------
  // register reads
  // --------------------------------------------------------------------
  // a function result cannot be part-selected, so the formatted word is a net
  assign fmt_word = fmt_result(accum_q, acc_cfg_q[`ADCP_SJ_MSB:`ADCP_SJ_LSB]); // R15

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `ADCP_ADDR_ACC_CFG: begin
          sfr_rdata_q <= acc_cfg_q & ~(8'h01 << `ADCP_ACC_EN_BIT); // R1
        end
        `ADCP_ADDR_PWR_CTL: begin
          sfr_rdata_q <= pwr_ctl_q;
        end
        `ADCP_ADDR_RES_LO: begin
          sfr_rdata_q <= fmt_word[7:0]; // R15
        end
        `ADCP_ADDR_RES_HI: begin
          sfr_rdata_q <= fmt_word[15:8]; // R15
        end
        default: begin
          sfr_rdata_q <= 8'h00;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  always_comb begin
    timer_load = 1'b0;
    timer_osc = 8'h00;
    timer_sar = delayed_track_select ? `ADCP_TRACK_EXTRA : 2'h0; // R11 R13
    unique case (state_q)
      ADCP_IDLE: begin
        if (start_of_conversion && burst_enable) begin
          timer_load = 1'b1;
          timer_osc = `ADCP_PWR_MULT * {4'h0, pwr_ctl_q[`ADCP_PWR_MSB:`ADCP_PWR_LSB]}; // R10
        end else if (start_of_conversion && delayed_track_select) begin
          timer_load = 1'b1; // R13
        end
      end
      ADCP_CONV: begin
        if (conv_result_valid && burst_q && remaining_q > 7'h01) begin
          timer_load = 1'b1;
          timer_osc = `ADCP_BTRACK_BASE - {2'h0, burst_track_delay};
        end
      end
      ADCP_PWRUP, ADCP_BTRACK: begin
        timer_load = 1'b0;
      end
    endcase
  end

  assign take_result = (state_q == ADCP_CONV) && conv_result_valid;
  assign done_set = take_result && (!burst_q || remaining_q <= 7'h01); // R12

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ADCP_IDLE;
      burst_q <= 1'b0;
      remaining_q <= 7'h00;
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      unique case (state_q)
        ADCP_IDLE: begin
          if (start_of_conversion) begin
            burst_q <= burst_enable;
            remaining_q <= burst_enable ? rpt_count(acc_cfg_q[`ADCP_RPT_MSB:`ADCP_RPT_LSB])
                                        : 7'h01; // R6
            if (timer_load) begin
              state_q <= ADCP_PWRUP; // R14
            end else begin
              conv_start_q <= 1'b1;
              state_q <= ADCP_CONV;
            end
          end
        end
        ADCP_PWRUP, ADCP_BTRACK: begin
          if (timer_done) begin
            conv_start_q <= 1'b1;
            state_q <= ADCP_CONV;
          end
        end
        ADCP_CONV: begin
          if (conv_result_valid) begin
            remaining_q <= remaining_q - 7'h01;
            state_q <= timer_load ? ADCP_BTRACK : ADCP_IDLE; // R6
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tracking_q <= 1'b0;
    end else begin
      tracking_q <= timer_load || ((state_q == ADCP_PWRUP || state_q == ADCP_BTRACK)
                                   && !timer_done); // R13
    end
  end

  adcp_delay_timer u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(timer_load),
    .osc_count(timer_osc),
    .sar_count(timer_sar),
    .osc_tick(high_freq_oscillator_tick),
    .sar_tick(converter_clock_tick),
    .done_q(timer_done)
  );

  // --------------------------------------------------------------------
  // accumulator
  // --------------------------------------------------------------------
  assign conv_ext = {6'h00, conv_result};

  // a result landing with a software write to the same word wins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      accum_q <= `ADCP_RES_RST;
      first_q <= 1'b0;
    end else begin
      if (state_q == ADCP_IDLE && start_of_conversion) begin
        first_q <= 1'b1;
      end else if (take_result) begin
        first_q <= 1'b0;
      end
      if (take_result) begin
        if (burst_q) begin
          accum_q <= first_q ? conv_ext : accum_q + conv_ext; // R6
        end else if (accumulate_enable_q) begin
          accum_q <= accum_q + conv_ext; // R3 R15
        end else begin
          accum_q <= conv_ext; // R2
        end
      end else if (sfr_wr && sfr_addr == `ADCP_ADDR_RES_LO) begin
        accum_q[7:0] <= sfr_wdata;
      end else if (sfr_wr && sfr_addr == `ADCP_ADDR_RES_HI) begin
        accum_q[15:8] <= sfr_wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // completion flag: a set in the clearing cycle wins
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conversion_done_flag_q <= 1'b0;
    end else if (done_set) begin
      conversion_done_flag_q <= 1'b1; // R12
    end else if (conversion_done_clear) begin
      conversion_done_flag_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== sim/adcp_top_sva.sv ====
// assertion checker for the converter accumulate and power control block
// assumes it is bound to adcp_top and sees only that module's ports
`default_nettype none
module adcp_top_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata_q,
  // converter side
  input wire logic burst_enable,
  input wire logic delayed_track_select,
  input wire logic start_of_conversion,
  input wire logic conv_result_valid,
  input wire logic conv_start_q,
  input wire logic low_power_buffer_enable_q,
  input wire logic conversion_done_clear,
  input wire logic conversion_done_flag_q
);
  logic busy_q;
  logic flag_q;
  logic [3:0] pwr_q;
  wire logic go_ok;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // helpers: busy spans start to flag rise, mirror of power-up field
  // ----
  assign go_ok = start_of_conversion && !busy_q;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      flag_q <= 1'b0;
      pwr_q <= 4'hf;
    end else begin
      flag_q <= conversion_done_flag_q;
      if (start_of_conversion) begin
        busy_q <= 1'b1;
      end else if (conversion_done_flag_q && !flag_q) begin
        busy_q <= 1'b0;
      end
      if (sfr_wr && sfr_addr == 8'hbb) begin
        pwr_q <= sfr_wdata[3:0];
      end
    end
  end
  // ----
  // properties
  // ----
  a_acc_en_zero: assert property (
    sfr_rd && sfr_addr == 8'hba |=> !sfr_rdata_q[6]) else $error("enable bit read as one");
  a_lp_follows: assert property (
    sfr_wr && sfr_addr == 8'hbb ##1 !(sfr_wr && sfr_addr == 8'hbb)
    |=> low_power_buffer_enable_q == $past(sfr_wdata[7], 2)) else $error("low power level wrong");
  a_flag_sticky: assert property (
    conversion_done_flag_q && !conversion_done_clear |=> conversion_done_flag_q)
    else $error("done flag dropped");
  a_flag_clear: assert property (
    conversion_done_clear && !conv_result_valid |=> !conversion_done_flag_q)
    else $error("done flag not cleared");
  a_flag_single: assert property (
    conv_result_valid && !burst_enable |=> conversion_done_flag_q) else $error("flag not set");
  a_start_now: assert property (
    go_ok && !delayed_track_select && !burst_enable |=> conv_start_q) else $error("start late");
  a_start_late: assert property (
    go_ok && delayed_track_select && !burst_enable |=> !conv_start_q [*3])
    else $error("start before track delay");
  a_burst_wait: assert property (
    go_ok && burst_enable && pwr_q != 4'h0 |=> !conv_start_q [*8]) else $error("no power-up wait");
endmodule
bind adcp_top adcp_top_sva i_adcp_top_sva (.sys_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata_q, .burst_enable, .delayed_track_select, .start_of_conversion,
  .conv_result_valid, .conv_start_q, .low_power_buffer_enable_q, .conversion_done_clear,
  .conversion_done_flag_q);
`default_nettype wire

// ==== sim/adcp_top_tb.sv ====
// self-checking bench for the converter accumulate and power control block
// assumes the design and the bound checker are compiled before it
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module adcp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, sys_rst, sfr_wr, sfr_rd, burst_enable, delayed_track_select;
  logic high_freq_oscillator_tick, converter_clock_tick, start_of_conversion;
  logic conv_result_valid, conversion_done_clear, conv_start_q, tracking_q;
  logic low_power_buffer_enable_q, conversion_done_flag_q;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, rd_v;
  logic [9:0] conv_result;
  logic [5:0] burst_track_delay;
  logic [1:0] div_q;
  logic [15:0] exp_v;
  int miscompares, tests_run, n, cnt;
  adcp_top i_adcp_top (.sys_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata_q, .burst_enable, .delayed_track_select, .burst_track_delay,
    .high_freq_oscillator_tick, .converter_clock_tick, .start_of_conversion,
    .conv_result_valid, .conv_result, .conv_start_q, .tracking_q,
    .low_power_buffer_enable_q, .conversion_done_clear, .conversion_done_flag_q);
  // ----
  // clock, rate enables and bus tasks
  // ----
  always #25 sys_clk = ~sys_clk;
  // oscillator tick every 2 cycles, converter tick every 4
  always @(posedge sys_clk) begin
    div_q <= div_q + 2'h1;
    high_freq_oscillator_tick <= div_q[0];
    converter_clock_tick <= div_q == 2'h3;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1 rd_v = sfr_rdata_q;
  endtask
  task automatic go();
    @(posedge sys_clk);
    start_of_conversion <= 1'b1;
    @(posedge sys_clk);
    start_of_conversion <= 1'b0;
    #1;
  endtask
  // bounded wait for the converter start pulse, n holds the cycles taken
  task automatic wst();
    n = 0;
    while (conv_start_q !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask
  task automatic res(input logic [9:0] d);
    @(posedge sys_clk);
    conv_result_valid <= 1'b1;
    conv_result <= d;
    @(posedge sys_clk);
    conv_result_valid <= 1'b0;
    #1;
  endtask
  task automatic clr();
    @(posedge sys_clk);
    conversion_done_clear <= 1'b1;
    @(posedge sys_clk);
    conversion_done_clear <= 1'b0;
    #1;
  endtask
  task automatic conv(input logic [9:0] d);
    go();
    wst();
    res(d);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rd(8'hbb);
    `CHK(rd_v, 8'h0f)
    rd(8'h10);
    `CHK(rd_v, 8'h00)
    wr(8'hba, 8'h60);
    rd(8'hba);
    `CHK(rd_v, 8'h20)
    $display("t_regs done");
  endtask
  task automatic t_single();
    wr(8'hba, 8'h00);
    conv(10'h155);
    `CHK(conversion_done_flag_q, 1'b1)
    clr();
    `CHK(conversion_done_flag_q, 1'b0)
    conv(10'h2aa);
    clr();
    rd(8'hd3);
    `CHK(rd_v, 8'h02)
    rd(8'hd2);
    `CHK(rd_v, 8'haa)
    $display("t_single done");
  endtask
  task automatic t_accum();
    wr(8'hd3, 8'h00);
    wr(8'hd2, 8'h00);
    wr(8'hba, 8'h40);
    conv(10'h3ff);
    clr();
    conv(10'h201);
    clr();
    for (int s = 0; s < 5; s++) begin
      exp_v = (s == 4) ? 16'h0600 << 6 : 16'h0600 >> s;
      wr(8'hba, 8'(s << 3));
      rd(8'hd3);
      `CHK(rd_v, exp_v[15:8])
      rd(8'hd2);
      `CHK(rd_v, exp_v[7:0])
    end
    $display("t_accum done");
  endtask
  task automatic t_lp();
    wr(8'hbb, 8'h8f);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(low_power_buffer_enable_q, 1'b1)
    rd(8'hbb);
    `CHK(rd_v, 8'h8f)
    wr(8'hbb, 8'h0f);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(low_power_buffer_enable_q, 1'b0)
    $display("t_lp done");
  endtask
  task automatic t_delay();
    @(posedge sys_clk);
    delayed_track_select <= 1'b1;
    go();
    @(posedge sys_clk);
    #1 `CHK(tracking_q, 1'b1)
    wst();
    `CHK(n >= 7, 1'b1)
    res(10'h0aa);
    clr();
    // burst with delayed tracking: power-up wait plus three converter clocks
    @(posedge sys_clk);
    burst_enable <= 1'b1;
    wr(8'hbb, 8'h01);
    go();
    wst();
    `CHK(n >= 24 && n <= 32, 1'b1)
    res(10'h0aa);
    `CHK(conversion_done_flag_q, 1'b1)
    clr();
    @(posedge sys_clk);
    burst_enable <= 1'b0;
    @(posedge sys_clk);
    delayed_track_select <= 1'b0;
    $display("t_delay done");
  endtask
  // repeat codes 0 to 5; the flag must wait for the last result of the burst
  task automatic t_burst();
    @(posedge sys_clk);
    burst_enable <= 1'b1;
    wr(8'hbb, 8'h01);
    for (int c = 0; c < 6; c++) begin
      cnt = (c == 0) ? 1 : 4 << (c - 1);
      wr(8'hba, 8'(c));
      go();
      wst();
      `CHK(n >= 14 && n <= 21, 1'b1)
      for (int k = 1; k <= cnt; k++) begin
        if (k > 1) wst();
        res(10'h001);
        `CHK(conversion_done_flag_q, k == cnt)
      end
      clr();
      rd(8'hd2);
      `CHK(rd_v, 8'(cnt))
    end
    @(posedge sys_clk);
    burst_enable <= 1'b0;
    $display("t_burst done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {sys_clk, sfr_wr, sfr_rd, burst_enable, delayed_track_select, div_q} = '0;
    {high_freq_oscillator_tick, converter_clock_tick, start_of_conversion} = '0;
    {conv_result_valid, conversion_done_clear, sfr_addr, sfr_wdata, conv_result} = '0;
    burst_track_delay = 6'h3c;
    sys_rst = 1'b1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_single();
    t_accum();
    t_lp();
    t_delay();
    t_burst();
    results();
  end
  // the whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    results();
  end
endmodule
`undef CHK
`default_nettype wire
